// File: dv/rmc_media_model.sv
// Media-side model: answers each sector fetch with 256 words, then a done pulse
// Assumes the pclk handshake of rmc_top; err_en and idnf_en mark the sector as failed
`timescale 1ns/1ns
`default_nettype none
module rmc_media_model
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        media_req,
   input  wire logic [47:0] media_lba,
   input  wire logic        err_en,
   input  wire logic        idnf_en,
   output var  logic        media_word_valid,
   output var  logic [15:0] media_word,
   output var  logic        media_done,
   output var  logic        media_err,
   output var  logic        media_idnf
);
   logic [8:0] n;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         n <= 9'h0;
         media_word_valid <= 1'b0;
         media_word <= 16'h0;
         media_done <= 1'b0;
         media_err <= 1'b0;
         media_idnf <= 1'b0;
      end
      else
      begin
         media_word_valid <= 1'b0;
         media_done <= 1'b0;
         media_word <= ~media_word;
         media_err <= 1'($urandom);
         media_idnf <= 1'($urandom);
         if (media_req && !media_done && n == 9'h100)
         begin
            n <= 9'h0;
            media_done <= 1'b1;
            media_err <= err_en;
            media_idnf <= idnf_en;
         end
         else if (media_req && !media_done && $urandom % 3 != 0)
         begin
            n <= n + 9'h1;
            media_word_valid <= 1'b1;
            media_word <= media_lba[15:0] ^ media_lba[31:16] ^ media_lba[47:32] ^ {n[7:0], ~n[7:0]};
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/rmc_top_chk.sv
// Port checker for rmc_top
// Assumes it is bound to rmc_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module rmc_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        intrq,
   input wire logic        media_req,
   input wire logic [47:0] media_lba,
   input wire logic        media_word_valid,
   input wire logic [15:0] media_word,
   input wire logic        media_done,
   input wire logic        media_err,
   input wire logic        media_idnf
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   rdy_timing_a:
      assert property (psel && penable && !pready |=> pready) else $error("pready late");
   rdy_pulse_a:
      assert property (pready |=> !pready) else $error("pready too long");
   slverr_data_a:
      assert property (pslverr |-> pready && (pwrite || prdata == 32'h0)) else $error("bad slave error");
   unmapped_err_a:
      assert property (psel && penable && !pready && paddr > 8'h24 |=> pslverr) else $error("no slave error");
   lba_hold_a:
      assert property (media_req && !media_done |=> media_req && $stable(media_lba)) else $error("fetch moved");
   lba_step_a:
      assert property (media_req && media_done ##1 media_req |-> media_lba == $past(media_lba) + 48'h1)
         else $error("next sector wrong");
   int_rise_a:
      assert property ($rose(intrq) |-> !media_req) else $error("interrupt while fetching");
   int_fall_a:
      assert property ($fell(intrq) |-> (pready || $past(pready)) && paddr == 8'h1c)
         else $error("interrupt cleared wrongly");
   cover property ($rose(media_req));
   cover property ($rose(intrq));
   cover property (pslverr);
endmodule
bind rmc_top rmc_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .intrq(intrq), .media_req(media_req), .media_lba(media_lba),
   .media_word_valid(media_word_valid), .media_word(media_word), .media_done(media_done),
   .media_err(media_err), .media_idnf(media_idnf));
`default_nettype wire

// File: dv/tb_read_multiple_command_handler.sv
// Testbench for the block-mode read command handler
// Assumes rmc_top, the media model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_read_multiple_command_handler;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic        err_en = 1'b0;
   logic        idnf_en = 1'b0;
   logic [31:0] rd;
   logic        se;
   logic [47:0] l;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          c;
   wire  [31:0] prdata;
   wire  [47:0] media_lba;
   wire  [15:0] media_word;
   wire         pready, pslverr, intrq, media_req, media_word_valid, media_done, media_err, media_idnf;

   always #20 pclk = ~pclk;

   rmc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .intrq(intrq),
      .media_req(media_req), .media_lba(media_lba), .media_word_valid(media_word_valid),
      .media_word(media_word), .media_done(media_done), .media_err(media_err), .media_idnf(media_idnf));
   rmc_media_model media (.pclk(pclk), .presetn(presetn), .media_req(media_req), .media_lba(media_lba),
      .err_en(err_en), .idnf_en(idnf_en), .media_word_valid(media_word_valid), .media_word(media_word),
      .media_done(media_done), .media_err(media_err), .media_idnf(media_idnf));

   task end_sim;
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         n_mismatch++;
         $display("Error %0t: timeout", $time);
         end_sim;
      end
   end

   task cmp(input [31:0] g, input [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask

   task apb(input [7:0] a, input w, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input [7:0] a, input [31:0] d);
      apb(a, 1'b1, d);
   endtask

   task rdc(input [7:0] a, input [7:0] e);
      apb(a, 1'b0, 32'h0);
      cmp(rd, {24'h0, e});
   endtask

   task wait_int;
      int t;
      t = 0;
      while (intrq !== 1'b1 && t < 8000)
      begin
         @(posedge pclk);
         t++;
      end
      if (intrq !== 1'b1)
      begin
         n_mismatch++;
         $display("Error %0t: no interrupt", $time);
      end
   endtask

   function [15:0] exp_w(input [47:0] x, input [7:0] n);
      return x[15:0] ^ x[31:16] ^ x[47:32] ^ {n, ~n};
   endfunction

   task setx(input [47:0] x, input [15:0] n);
      wr(8'h08, {24'h0, n[15:8]});
      wr(8'h08, {24'h0, n[7:0]});
      wr(8'h0c, {24'h0, x[31:24]});
      wr(8'h0c, {24'h0, x[7:0]});
      wr(8'h10, {24'h0, x[39:32]});
      wr(8'h10, {24'h0, x[15:8]});
      wr(8'h14, {24'h0, x[47:40]});
      wr(8'h14, {24'h0, x[23:16]});
      wr(8'h18, 32'he0);
   endtask

   task drain(input [47:0] x, input int cnt, input int bs);
      int left;
      int k;
      left = cnt;
      while (left > 0)
      begin
         k = left < bs ? left : bs;
         wait_int;
         rdc(8'h1c, 8'h58);
         for (int s = 0; s < k * 256; s++)
         begin
            apb(8'h00, 1'b0, 32'h0);
            cmp(rd, {16'h0, exp_w(x + 48'(s / 256), 8'(s))});
         end
         x = x + 48'(k);
         left = left - k;
      end
      rdc(8'h1c, 8'h50);
   endtask

   initial
   begin
      void'($urandom(32'hcfbb6231));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdc(8'h18, 8'ha0);
      rdc(8'h24, 8'h00);
      apb(8'h28, 1'b0, 32'h0);
      cmp({31'h0, se}, 32'h1);
      wr(8'h1c, 32'hc4);
      wait_int;
      rdc(8'h1c, 8'h51);
      rdc(8'h04, 8'h04);
      l = {20'h0, 28'($urandom)};
      c = 2 + $urandom % 2;
      wr(8'h24, 32'h2);
      wr(8'h08, 32'(c));
      wr(8'h0c, {24'h0, l[7:0]});
      wr(8'h10, {24'h0, l[15:8]});
      wr(8'h14, {24'h0, l[23:16]});
      wr(8'h18, {24'h0, 4'he, l[27:24]});
      wr(8'h1c, 32'hc4);
      drain(l, c, 2);
      l = {$urandom, 16'($urandom)};
      c = 1 + $urandom % 3;
      setx(l, 16'(c));
      wr(8'h1c, 32'h29);
      drain(l, c, 2);
      err_en <= 1'b1;
      wr(8'h24, 32'h1);
      l = {$urandom, 16'($urandom)};
      setx(l, 16'h1);
      wr(8'h1c, 32'h29);
      wait_int;
      rdc(8'h1c, 8'h51);
      rdc(8'h04, 8'h40);
      rdc(8'h0c, l[7:0]);
      rdc(8'h10, l[15:8]);
      rdc(8'h14, l[23:16]);
      wr(8'h20, 32'h80);
      rdc(8'h0c, l[31:24]);
      rdc(8'h10, l[39:32]);
      rdc(8'h14, l[47:40]);
      wr(8'h24, 32'h11);
      wr(8'h1c, 32'h29);
      wait_int;
      rdc(8'h04, 8'h04);
      rdc(8'h1c, 8'h51);
      idnf_en <= 1'b1;
      wr(8'h24, 32'h1);
      wr(8'h1c, 32'hc4);
      wait_int;
      rdc(8'h1c, 8'h51);
      rdc(8'h04, 8'h10);
      rdc(8'h0c, l[7:0]);
      rdc(8'h10, l[15:8]);
      end_sim;
   end
endmodule
`default_nettype wire

// File: hdl/rmc_block_buf.v
// Word buffer that holds one block of sector data
// Assumes one write port from the media side and one read port from the bus side
`timescale 1ns/1ns
`default_nettype none

module rmc_block_buf
#(
   parameter DW = 16,
   parameter AW = 12
)
(
   input  wire          pclk,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data,
   input  wire [AW-1:0] rd_addr,
   output reg  [DW-1:0] rd_data
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // ****************************************
   // Storage and registered read
   // ****************************************
   always @(posedge pclk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule

`default_nettype wire

// File: hdl/rmc_top.v
// Block-mode read command handler: shadow registers, command engine, block buffer
// Assumes an APB master, a media engine on pclk, and a host that polls the data register
//
// What this block does
// - Command code c4h starts the 28-bit block-mode read.
// - Command code 29h starts the 48-bit read using current and previous registers.
// - Sectors are fetched from the media before their data goes to the host.
// - Sector data leaves through the data register sixteen bits per read.
// - One host interrupt per block; block size comes from the set-block-size value.
// - Otherwise both commands run like the ordinary single-interrupt sector read.
// - Extended count is previous byte above current byte, sixteen bits.
// - Extended count of zero means 65536 sectors.
// - Extended LBA takes current bytes low and previous bytes high.
// - Media error loads first failing LBA; upper bytes read with high-byte select.
`timescale 1ns/1ns
`default_nettype none
`include "rmc_consts.vh"

module rmc_top
#(
   parameter MAX_MULT = 16,
   parameter BUF_AW   = 12
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         intrq,
   output reg         media_req,
   output reg  [47:0] media_lba,
   input  wire        media_word_valid,
   input  wire [15:0] media_word,
   input  wire        media_done,
   input  wire        media_err,
   input  wire        media_idnf
);

   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_XFER = 2'd2;

   reg  [1:0]        state_reg;
   reg  [15:0]       cnt_reg;
   reg  [15:0]       sn_reg;
   reg  [15:0]       cl_reg;
   reg  [15:0]       ch_reg;
   reg  [7:0]        dh_reg;
   reg  [7:0]        mult_reg;
   reg               hob_reg;
   reg               nien_reg;
   reg  [7:0]        err_reg;
   reg               bsy_reg;
   reg               drq_reg;
   reg               errb_reg;
   reg               ext_reg;
   reg  [16:0]       left_reg;
   reg  [47:0]       lba_reg;
   reg  [7:0]        blk_reg;
   reg  [BUF_AW-1:0] wr_ptr_reg;
   reg  [BUF_AW-1:0] rd_ptr_reg;
   reg  [BUF_AW:0]   words_reg;
   reg  [31:0]       rd_mux;
   reg               mapped;
   wire [15:0]       buf_q;
   wire              acc;
   wire              wr_ok;
   wire              cmd_wr;
   wire              pop;
   wire              is_ext;
   wire              cmd_ok;
   wire [16:0]       cnt_load;
   wire [47:0]       lba_load;
   wire [7:0]        blk_inc;
   wire [15:0]       blk_words;
   wire [7:0]        status;
   wire              irq_set;

   // ****************************************
   // Bus decode
   // ****************************************
   assign acc    = psel & penable & ~pready;
   assign wr_ok  = acc & pwrite & (state_reg == ST_IDLE);
   assign cmd_wr = wr_ok & (paddr == `RMC_OFF_CMD);
   assign pop    = acc & ~pwrite & (paddr == `RMC_OFF_DATA) & drq_reg;
   assign irq_set = ~nien_reg;

   assign is_ext = (pwdata[7:0] == `RMC_CMD_RDMUL_X);
   assign cmd_ok = ((pwdata[7:0] == `RMC_CMD_RDMUL) | is_ext)
                 & (mult_reg != 8'h00) & ({24'h0, mult_reg} <= MAX_MULT);

   assign cnt_load = is_ext ?
      ((cnt_reg == 16'h0000) ? `RMC_CNT_MAX_X : {1'b0, cnt_reg}) :
      ((cnt_reg[7:0] == 8'h00) ? `RMC_CNT_MAX_28 : {9'h000, cnt_reg[7:0]});
   assign lba_load = is_ext ?
      {ch_reg[15:8], cl_reg[15:8], sn_reg[15:8], ch_reg[7:0], cl_reg[7:0], sn_reg[7:0]} :
      {20'h00000, dh_reg[3:0], ch_reg[7:0], cl_reg[7:0], sn_reg[7:0]};

   assign blk_inc   = blk_reg + 8'h01;
   assign blk_words = {blk_inc, 8'h00};

   assign status = {bsy_reg, 1'b1, 1'b0, 1'b1, drq_reg, 1'b0, 1'b0, errb_reg};

   always @*
   begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         `RMC_OFF_DATA: rd_mux = drq_reg ? {16'h0000, buf_q} : 32'h00000000;
         `RMC_OFF_ERR:  rd_mux = {24'h000000, err_reg};
         `RMC_OFF_CNT:  rd_mux = {24'h000000, hob_reg ? cnt_reg[15:8] : cnt_reg[7:0]};
         `RMC_OFF_SN:   rd_mux = {24'h000000, hob_reg ? sn_reg[15:8] : sn_reg[7:0]};
         `RMC_OFF_CL:   rd_mux = {24'h000000, hob_reg ? cl_reg[15:8] : cl_reg[7:0]};
         `RMC_OFF_CH:   rd_mux = {24'h000000, hob_reg ? ch_reg[15:8] : ch_reg[7:0]};
         `RMC_OFF_DH:   rd_mux = {24'h000000, dh_reg};
         `RMC_OFF_CMD:  rd_mux = {24'h000000, status};
         `RMC_OFF_CTRL: rd_mux = {24'h000000, hob_reg, 5'h00, nien_reg, 1'b0};
         `RMC_OFF_MULT: rd_mux = {24'h000000, mult_reg};
         default:
         begin
            mapped = 1'b0;
            rd_mux = 32'h00000000;
         end
      endcase
   end

   // ****************************************
   // Block buffer
   // ****************************************
   rmc_block_buf #(.DW(16), .AW(BUF_AW)) u_buf
   (
      .pclk    (pclk),
      .wr_en   (media_word_valid & (state_reg == ST_WAIT)),
      .wr_addr (wr_ptr_reg),
      .wr_data (media_word),
      .rd_addr (rd_ptr_reg),
      .rd_data (buf_q)
   );

   // ****************************************
   // Registers and command engine
   // ****************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata     <= 32'h00000000;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         intrq      <= 1'b0;
         media_req  <= 1'b0;
         media_lba  <= 48'h000000000000;
         state_reg  <= ST_IDLE;
         cnt_reg    <= 16'h0000;
         sn_reg     <= 16'h0000;
         cl_reg     <= 16'h0000;
         ch_reg     <= 16'h0000;
         dh_reg     <= `RMC_RST_DH;
         mult_reg   <= `RMC_RST_MULT;
         hob_reg    <= 1'b0;
         nien_reg   <= 1'b0;
         err_reg    <= 8'h00;
         bsy_reg    <= 1'b0;
         drq_reg    <= 1'b0;
         errb_reg   <= 1'b0;
         ext_reg    <= 1'b0;
         left_reg   <= 17'h00000;
         lba_reg    <= 48'h000000000000;
         blk_reg    <= 8'h00;
         wr_ptr_reg <= {BUF_AW{1'b0}};
         rd_ptr_reg <= {BUF_AW{1'b0}};
         words_reg  <= {(BUF_AW+1){1'b0}};
      end
      else
      begin
         pready  <= acc;
         pslverr <= acc & ~mapped;
         if (acc & ~pwrite)
         begin
            prdata <= rd_mux;
         end
         if (acc & ~pwrite & (paddr == `RMC_OFF_CMD))
         begin
            intrq <= 1'b0;
         end
         if (acc & pwrite & (paddr == `RMC_OFF_CTRL))
         begin
            hob_reg  <= pwdata[`RMC_CTL_HOB];
            nien_reg <= pwdata[`RMC_CTL_NIEN];
         end
         if (wr_ok)
         begin
            case (paddr)
               `RMC_OFF_CNT:  cnt_reg  <= {cnt_reg[7:0], pwdata[7:0]};
               `RMC_OFF_SN:   sn_reg   <= {sn_reg[7:0], pwdata[7:0]};
               `RMC_OFF_CL:   cl_reg   <= {cl_reg[7:0], pwdata[7:0]};
               `RMC_OFF_CH:   ch_reg   <= {ch_reg[7:0], pwdata[7:0]};
               `RMC_OFF_DH:   dh_reg   <= pwdata[7:0];
               `RMC_OFF_MULT: mult_reg <= pwdata[7:0];
               default:       ;
            endcase
            if (paddr != `RMC_OFF_CTRL && paddr != `RMC_OFF_MULT)
            begin
               hob_reg <= 1'b0;
            end
         end
         case (state_reg)
            ST_IDLE:
            begin
               if (cmd_wr)
               begin
                  intrq    <= 1'b0;
                  err_reg  <= 8'h00;
                  errb_reg <= 1'b0;
                  if (cmd_ok)
                  begin
                     ext_reg    <= is_ext;
                     left_reg   <= cnt_load;
                     lba_reg    <= lba_load;
                     media_lba  <= lba_load;
                     media_req  <= 1'b1;
                     bsy_reg    <= 1'b1;
                     blk_reg    <= 8'h00;
                     wr_ptr_reg <= {BUF_AW{1'b0}};
                     state_reg  <= ST_WAIT;
                  end
                  else
                  begin
                     errb_reg <= 1'b1;
                     err_reg  <= 8'h01 << `RMC_ER_ABT;
                     intrq    <= irq_set;
                  end
               end
            end
            ST_WAIT:
            begin
               if (media_word_valid)
               begin
                  wr_ptr_reg <= wr_ptr_reg + {{(BUF_AW-1){1'b0}}, 1'b1};
               end
               if (media_done)
               begin
                  media_req <= 1'b0;
                  if (media_err | media_idnf)
                  begin
                     if (ext_reg)
                     begin
                        sn_reg <= {lba_reg[31:24], lba_reg[7:0]};
                        cl_reg <= {lba_reg[39:32], lba_reg[15:8]};
                        ch_reg <= {lba_reg[47:40], lba_reg[23:16]};
                     end
                     else
                     begin
                        sn_reg[7:0] <= lba_reg[7:0];
                        cl_reg[7:0] <= lba_reg[15:8];
                        ch_reg[7:0] <= lba_reg[23:16];
                        dh_reg[3:0] <= lba_reg[27:24];
                     end
                     errb_reg  <= 1'b1;
                     err_reg   <= media_idnf ? (8'h01 << `RMC_ER_IDN) : (8'h01 << `RMC_ER_UNC);
                     bsy_reg   <= 1'b0;
                     intrq     <= irq_set;
                     state_reg <= ST_IDLE;
                  end
                  else
                  begin
                     left_reg <= left_reg - 17'h00001;
                     lba_reg  <= lba_reg + 48'h000000000001;
                     blk_reg  <= blk_inc;
                     if (blk_inc == mult_reg || left_reg == 17'h00001)
                     begin
                        bsy_reg    <= 1'b0;
                        drq_reg    <= 1'b1;
                        intrq      <= irq_set;
                        rd_ptr_reg <= {BUF_AW{1'b0}};
                        words_reg  <= blk_words[BUF_AW:0];
                        state_reg  <= ST_XFER;
                     end
                     else
                     begin
                        media_req <= 1'b1;
                        media_lba <= lba_reg + 48'h000000000001;
                     end
                  end
               end
            end
            ST_XFER:
            begin
               if (pop)
               begin
                  rd_ptr_reg <= rd_ptr_reg + {{(BUF_AW-1){1'b0}}, 1'b1};
                  words_reg  <= words_reg - {{BUF_AW{1'b0}}, 1'b1};
                  if (words_reg == {{BUF_AW{1'b0}}, 1'b1})
                  begin
                     drq_reg <= 1'b0;
                     if (left_reg == 17'h00000)
                     begin
                        state_reg <= ST_IDLE;
                     end
                     else
                     begin
                        bsy_reg    <= 1'b1;
                        blk_reg    <= 8'h00;
                        wr_ptr_reg <= {BUF_AW{1'b0}};
                        media_req  <= 1'b1;
                        media_lba  <= lba_reg;
                        state_reg  <= ST_WAIT;
                     end
                  end
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// File: pkg/rmc_consts.vh
// Constants of the block-mode read command handler
// Assumes an APB register window with one 32-bit word per register
`ifndef RMC_CONSTS_VH
`define RMC_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RMC_OFF_DATA   8'h00
`define RMC_OFF_ERR    8'h04
`define RMC_OFF_CNT    8'h08
`define RMC_OFF_SN     8'h0c
`define RMC_OFF_CL     8'h10
`define RMC_OFF_CH     8'h14
`define RMC_OFF_DH     8'h18
`define RMC_OFF_CMD    8'h1c
`define RMC_OFF_CTRL   8'h20
`define RMC_OFF_MULT   8'h24

// ****************************************
// Command codes
// ****************************************
`define RMC_CMD_RDMUL    8'hc4
`define RMC_CMD_RDMUL_X  8'h29

// ****************************************
// Field positions
// ****************************************
`define RMC_ST_BSY   7
`define RMC_ST_RDY   6
`define RMC_ST_DF    5
`define RMC_ST_DSC   4
`define RMC_ST_DRQ   3
`define RMC_ST_COR   2
`define RMC_ST_IDX   1
`define RMC_ST_ERR   0
`define RMC_ER_UNC   6
`define RMC_ER_IDN   4
`define RMC_ER_ABT   2
`define RMC_CTL_HOB  7
`define RMC_CTL_NIEN 1

// ****************************************
// Reset values and counts
// ****************************************
`define RMC_RST_MULT    8'h00
`define RMC_RST_DH      8'ha0
`define RMC_SECT_LOG2   8
`define RMC_CNT_MAX_X   17'h10000
`define RMC_CNT_MAX_28  17'h00100

`endif
